// ===== core/lcd_pkg.sv
package lcd_pkg;

   // -------------------------------------------------
   // Register map
   // -------------------------------------------------
   localparam int ADDR_W = 7;
   localparam logic [6:0] OFS_DISPLAY_CONTROL = 7'h00;
   localparam logic [6:0] OFS_CHARGE_PUMP_CONTROL = 7'h01;
   localparam logic [6:0] OFS_PHASE_AND_PRESCALE = 7'h02;
   localparam logic [6:0] OFS_SEGMENT_PIN_ENABLE_0 = 7'h08;
   localparam logic [6:0] OFS_PIXEL_DATA_0 = 7'h40;

   // -------------------------------------------------
   // Reset values
   // -------------------------------------------------
   localparam logic [7:0] RST_DISPLAY_CONTROL = 8'h00;
   localparam logic [7:0] RST_CHARGE_PUMP_CONTROL = 8'h3C;
   localparam logic [7:0] RST_PHASE_AND_PRESCALE = 8'h00;
   localparam logic [7:0] RST_ZERO = 8'h00;

   // -------------------------------------------------
   // Field positions
   // -------------------------------------------------
   localparam int BIT_DRIVER_ENABLE = 7;
   localparam int BIT_SLEEP_DISABLE = 6;
   localparam int BIT_WRITE_ERROR = 5;
   localparam int POS_CLK_SRC = 3;
   localparam int POS_COMMONS = 0;
   localparam int BIT_PUMP_ENABLE = 7;
   localparam int POS_PEAK_LEVEL = 3;
   localparam int BIT_THIRD_LEVEL = 2;
   localparam int POS_REG_CLK = 0;
   localparam int BIT_WAVEFORM_TYPE = 7;
   localparam int BIT_HALF_LEVEL = 6;
   localparam int BIT_DRIVER_ACTIVE = 5;
   localparam int BIT_WRITE_ALLOW = 4;
   localparam int POS_PRESCALE = 0;
   localparam logic [7:0] CPC_WRITABLE = 8'hBF;
   localparam logic [7:0] PPS_WRITABLE = 8'hCF;

   // -------------------------------------------------
   // Timing and encodings
   // -------------------------------------------------
   localparam logic [12:0] FAST_RC_DIV = 13'h1FFF;
   localparam logic [12:0] SLOW_DIV = 13'h001F;
   localparam logic [4:0] SEG_COUNTS_LAST = 5'h1F;
   localparam logic [4:0] SEG_COUNTS_HALF = 5'h0F;
   localparam logic [4:0] TRANSITION_COUNTS = 5'h03;
   localparam logic [2:0] COMMONS_STATIC = 3'h0;
   localparam logic [2:0] COMMONS_THREE = 3'h2;
   localparam logic [2:0] COMMONS_FOUR = 3'h3;

   typedef enum logic [1:0] {
      CLK_FAST_RC = 2'h0,
      CLK_SECONDARY = 2'h1,
      CLK_LOW_POWER = 2'h2
   } lcd_clk_src_t;

   typedef enum logic [1:0] {
      BIAS_STATIC = 2'h0,
      BIAS_HALF = 2'h1,
      BIAS_THIRD = 2'h2
   } lcd_bias_t;

   // Settings handed to the analog regulator
   typedef struct packed {
      logic pumpEnable;
      logic [2:0] peakLevel;
      logic thirdLevelSupport;
      logic [1:0] regulatorClockSel;
      logic regulatorOn;
   } lcd_regulator_t;

endpackage

// ===== core/lcd_segment_ctrl.sv
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module lcd_segment_ctrl
   import lcd_pkg::*;
#(
   parameter int NUM_SEGS = 64,
   parameter int NUM_COMS = 8,
   parameter int MAX_SEGS_HIGH_MUX = 60
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Register port
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   // Oscillator ticks and power state
   input wire logic fastRcTick,
   input wire logic secOscTick,
   input wire logic lowPwrRcTick,
   input wire logic cpuSleep,
   // Panel side
   output logic [NUM_COMS-1:0] commonLine,
   output logic [NUM_SEGS-1:0] segmentLine,
   output logic framePhase,
   output logic [NUM_SEGS-1:0] segmentPinEnable,
   output lcd_bias_t biasMode,
   output lcd_regulator_t regulatorCfg,
   output logic ladderTransition,
   output logic driverActive
);

   // -------------------------------------------------
   // Register storage
   // -------------------------------------------------
   logic [7:0] displayControl_q;
   logic [7:0] chargePumpControl_q;
   logic [7:0] phasePrescale_q;
   logic [7:0] segEnable_q [0:7];
   logic [7:0] pixelData_q [0:63];
   logic [7:0] regRdata_q;

   logic active_q;
   logic writeAllow_q;
   logic [12:0] srcCnt_q;
   logic [15:0] preCnt_q;
   logic [4:0] segCnt_q;
   logic [2:0] comIdx_q;
   logic phase_q;
   logic ladderTrans_q;
   lcd_bias_t bias_q;
   lcd_regulator_t regCfg_q;
   logic [NUM_COMS-1:0] comOut_q;
   logic phaseOut_q;

   logic isCtrl, isPump, isPhase, isSegEn, isPixel;
   logic pixelWr;
   logic runDriver;
   logic srcTick, baseTick, preTick;
   logic [12:0] srcDivLast;
   logic [1:0] clkSel;
   logic [2:0] comSel;
   logic lastCount, lastCom;

   assign clkSel = displayControl_q[POS_CLK_SRC +: 2];
   assign comSel = displayControl_q[POS_COMMONS +: 3];

   // -------------------------------------------------
   // Address decode
   // -------------------------------------------------
   assign isCtrl = (regAddr == OFS_DISPLAY_CONTROL);
   assign isPump = (regAddr == OFS_CHARGE_PUMP_CONTROL);
   assign isPhase = (regAddr == OFS_PHASE_AND_PRESCALE);
   assign isSegEn = (regAddr[ADDR_W-1:3] == OFS_SEGMENT_PIN_ENABLE_0[ADDR_W-1:3]);
   assign isPixel = (regAddr[ADDR_W-1] == OFS_PIXEL_DATA_0[ADDR_W-1]);
   assign pixelWr = regWr && isPixel;

   // -------------------------------------------------
   // Control registers
   // -------------------------------------------------
   // Error flag is clear-only from software; a refused pixel write in the
   // same cycle still leaves it set.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         displayControl_q <= RST_DISPLAY_CONTROL;
      end else begin
         if (regWr && isCtrl) begin
            displayControl_q <= regWdata;
            displayControl_q[BIT_WRITE_ERROR] <= displayControl_q[BIT_WRITE_ERROR]
                                                 & regWdata[BIT_WRITE_ERROR];
         end
         if (pixelWr && !writeAllow_q) begin
            displayControl_q[BIT_WRITE_ERROR] <= 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         chargePumpControl_q <= RST_CHARGE_PUMP_CONTROL;
      end else if (regWr && isPump) begin
         chargePumpControl_q <= regWdata & CPC_WRITABLE;
      end
   end

   // Status bits live outside this register and are merged on read
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         phasePrescale_q <= RST_PHASE_AND_PRESCALE;
      end else if (regWr && isPhase) begin
         phasePrescale_q <= regWdata & PPS_WRITABLE;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 8; i++) begin
            segEnable_q[i] <= RST_ZERO;
         end
      end else if (regWr && isSegEn) begin
         segEnable_q[regAddr[2:0]] <= regWdata;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 64; i++) begin
            pixelData_q[i] <= RST_ZERO;
         end
      end else if (pixelWr && writeAllow_q) begin
         pixelData_q[regAddr[5:0]] <= regWdata;
      end
   end

   // -------------------------------------------------
   // Read port
   // -------------------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         regRdata_q <= RST_ZERO;
      end else if (regRd) begin
         if (isCtrl) begin
            regRdata_q <= displayControl_q;
         end else if (isPump) begin
            regRdata_q <= chargePumpControl_q;
         end else if (isPhase) begin
            regRdata_q <= phasePrescale_q;
            regRdata_q[BIT_DRIVER_ACTIVE] <= active_q;
            regRdata_q[BIT_WRITE_ALLOW] <= writeAllow_q;
         end else if (isSegEn) begin
            regRdata_q <= segEnable_q[regAddr[2:0]];
         end else if (isPixel) begin
            regRdata_q <= pixelData_q[regAddr[5:0]];
         end else begin
            regRdata_q <= RST_ZERO;
         end
      end else begin
         regRdata_q <= RST_ZERO;
      end
   end
   assign regRdata = regRdata_q;

   // -------------------------------------------------
   // Enable and sleep
   // -------------------------------------------------
   assign runDriver = displayControl_q[BIT_DRIVER_ENABLE]
                      && !(cpuSleep && displayControl_q[BIT_SLEEP_DISABLE]);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         active_q <= 1'b0;
      end else begin
         active_q <= runDriver;
      end
   end
   assign driverActive = active_q;

   // -------------------------------------------------
   // Clock source and prescaler
   // -------------------------------------------------
   always_comb begin
      case (clkSel)
         CLK_FAST_RC: begin
            srcTick = fastRcTick;
            srcDivLast = FAST_RC_DIV;
         end
         CLK_SECONDARY: begin
            srcTick = secOscTick;
            srcDivLast = SLOW_DIV;
         end
         default: begin
            srcTick = lowPwrRcTick;
            srcDivLast = SLOW_DIV;
         end
      endcase
   end

   // Fixed source divider, then the hidden 16-bit prescaler
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         srcCnt_q <= 13'h0000;
      end else if (!active_q) begin
         srcCnt_q <= 13'h0000;
      end else if (srcTick) begin
         srcCnt_q <= (srcCnt_q >= srcDivLast) ? 13'h0000 : srcCnt_q + 13'h0001;
      end
   end
   assign baseTick = srcTick && (srcCnt_q >= srcDivLast);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         preCnt_q <= 16'h0000;
      end else if (!active_q) begin
         preCnt_q <= 16'h0000;
      end else if (baseTick) begin
         preCnt_q <= preTick ? 16'h0000 : preCnt_q + 16'h0001;
      end
   end
   assign preTick = baseTick
                    && (preCnt_q >= {12'h000, phasePrescale_q[POS_PRESCALE +: 4]});

   // -------------------------------------------------
   // Segment time, commons scan and phase
   // -------------------------------------------------
   assign lastCount = (segCnt_q == SEG_COUNTS_LAST);
   assign lastCom = (comIdx_q >= comSel);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         segCnt_q <= 5'h00;
         comIdx_q <= 3'h0;
      end else if (!active_q) begin
         segCnt_q <= 5'h00;
         comIdx_q <= 3'h0;
      end else if (preTick) begin
         segCnt_q <= segCnt_q + 5'h01;
         if (lastCount) begin
            comIdx_q <= lastCom ? 3'h0 : comIdx_q + 3'h1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         phase_q <= 1'b0;
      end else if (!active_q) begin
         phase_q <= 1'b0;
      end else if (preTick) begin
         if (phasePrescale_q[BIT_WAVEFORM_TYPE]) begin
            if (lastCount && lastCom) begin
               phase_q <= ~phase_q;
            end
         end else if (lastCount || segCnt_q == SEG_COUNTS_HALF) begin
            phase_q <= ~phase_q;
         end
      end
   end
   assign framePhase = phaseOut_q;

   // Ladder runs in transition mode for the first counts of a segment time
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ladderTrans_q <= 1'b0;
      end else begin
         ladderTrans_q <= active_q && (segCnt_q < TRANSITION_COUNTS);
      end
   end
   assign ladderTransition = ladderTrans_q;

   // Pixel writes refused in the last prescaled count before a frame boundary,
   // while writes at any other count reach the live pixel data mid-frame.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         writeAllow_q <= 1'b1;
      end else begin
         writeAllow_q <= !active_q || !(lastCom && lastCount);
      end
   end

   // -------------------------------------------------
   // Bias and regulator settings
   // -------------------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         bias_q <= BIAS_STATIC;
      end else if (comSel == COMMONS_STATIC) begin
         bias_q <= BIAS_STATIC;
      end else if (comSel <= COMMONS_THREE && phasePrescale_q[BIT_HALF_LEVEL]) begin
         bias_q <= BIAS_HALF;
      end else begin
         bias_q <= BIAS_THIRD;
      end
   end
   assign biasMode = bias_q;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         regCfg_q <= '0;
      end else begin
         regCfg_q.pumpEnable <= chargePumpControl_q[BIT_PUMP_ENABLE];
         regCfg_q.peakLevel <= chargePumpControl_q[POS_PEAK_LEVEL +: 3];
         regCfg_q.thirdLevelSupport <= chargePumpControl_q[BIT_THIRD_LEVEL];
         regCfg_q.regulatorClockSel <= chargePumpControl_q[POS_REG_CLK +: 2];
         regCfg_q.regulatorOn <= |chargePumpControl_q[POS_REG_CLK +: 2];
      end
   end
   assign regulatorCfg = regCfg_q;

   // -------------------------------------------------
   // Panel drive
   // -------------------------------------------------
   // Selected common is driven to the active level of the current phase;
   // unselected and unused commons carry the opposite level.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         comOut_q <= '0;
         phaseOut_q <= 1'b0;
      end else begin
         phaseOut_q <= phase_q;
         for (int c = 0; c < NUM_COMS; c++) begin
            comOut_q[c] <= active_q && ((c == int'(comIdx_q)) ^ phase_q);
         end
      end
   end
   assign commonLine = comOut_q;

   genvar s;
   generate
      for (s = 0; s < NUM_SEGS; s++) begin : gSeg
         logic segOut_q;
         logic pinEn_q;
         logic pixelOn;
         logic segUsable;
         assign pixelOn = pixelData_q[{comIdx_q, 3'(s / 8)}][s % 8];
         assign segUsable = (s < MAX_SEGS_HIGH_MUX) || (comSel <= COMMONS_FOUR);
         always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
               segOut_q <= 1'b0;
               pinEn_q <= 1'b0;
            end else begin
               pinEn_q <= segEnable_q[s / 8][s % 8];
               // Dark pixel on a usable segment drives the selected common's level; clear or unusable drives opposite it
               segOut_q <= active_q && ((segUsable && pixelOn) ^ phase_q);
            end
         end
         assign segmentLine[s] = segOut_q;
         assign segmentPinEnable[s] = pinEn_q;
      end
   endgenerate

endmodule

`default_nettype wire

// ===== bench/lcd_properties.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_properties
   import lcd_pkg::*;
#(
   parameter int NUM_SEGS = 64,
   parameter int NUM_COMS = 8
) (
   // Clock, reset, register port and sleep
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regRdata,
   input wire logic cpuSleep,
   // Panel side
   input wire logic [NUM_COMS-1:0] commonLine,
   input wire logic [NUM_SEGS-1:0] segmentLine,
   input wire logic [NUM_SEGS-1:0] segmentPinEnable,
   input wire lcd_bias_t biasMode,
   input wire lcd_regulator_t regulatorCfg,
   input wire logic ladderTransition,
   input wire logic driverActive
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   logic [7:0] wd1_q, wd2_q;
   // --------------------------------
   // Write data history
   // --------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wd1_q <= 8'h00;
         wd2_q <= 8'h00;
      end else begin
         wd1_q <= regWdata;
         wd2_q <= wd1_q;
      end
   end
   sequence ctlWr;
      regWr && regAddr == OFS_DISPLAY_CONTROL;
   endsequence
   sequence onWr;
      regWr && regAddr == OFS_DISPLAY_CONTROL && regWdata[7:6] == 2'h2;
   endsequence
   sequence offWr;
      regWr && regAddr == OFS_DISPLAY_CONTROL && !regWdata[7];
   endsequence
   sequence sleepWr;
      regWr && regAddr == OFS_DISPLAY_CONTROL && regWdata[7:6] == 2'h3;
   endsequence
   sequence pumpWr;
      regWr && regAddr == OFS_CHARGE_PUMP_CONTROL;
   endsequence
   // --------------------------------
   // Properties
   // --------------------------------
   chk_read_idle: assert property (!regRd |=> regRdata == 8'h00)
      else $error("read data not idle");
   chk_enable_up: assert property (onWr |=> ##1 driverActive)
      else $error("driver did not start");
   chk_disable_down: assert property (offWr |=> ##1 !driverActive ##1
      (commonLine == '0 && segmentLine == '0)) else $error("driver did not stop");
   chk_sleep_stop: assert property (sleepWr ##1 cpuSleep [*2] |-> !driverActive)
      else $error("driver runs in sleep");
   chk_sleep_keep: assert property (onWr ##1 cpuSleep [*2] |-> driverActive)
      else $error("driver stopped in sleep");
   chk_pin_enable: assert property (regWr && regAddr == OFS_SEGMENT_PIN_ENABLE_0 + 7'h07
      |-> ##2 segmentPinEnable[63:56] == wd2_q) else $error("pin enable mismatch");
   chk_pump_level: assert property (pumpWr |-> ##2 (regulatorCfg.pumpEnable == wd2_q[7]
      && regulatorCfg.peakLevel == wd2_q[5:3])) else $error("pump level mismatch");
   chk_pump_clock: assert property (pumpWr |-> ##2 (regulatorCfg.regulatorClockSel == wd2_q[1:0]
      && regulatorCfg.regulatorOn == (wd2_q[1:0] != 2'h0) && regulatorCfg.thirdLevelSupport
      == wd2_q[2])) else $error("pump clock mismatch");
   chk_bias_map: assert property (ctlWr |-> ##2 ((wd2_q[2:0] != COMMONS_STATIC
      || biasMode == BIAS_STATIC) && (wd2_q[2:0] < COMMONS_FOUR || biasMode == BIAS_THIRD)))
      else $error("bias mismatch");
   chk_ladder_idle: assert property (!driverActive [*3] |-> !ladderTransition)
      else $error("ladder switching while idle");
endmodule
bind lcd_segment_ctrl lcd_properties #(.NUM_SEGS(NUM_SEGS), .NUM_COMS(NUM_COMS)) chk (
   .mclk, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .cpuSleep, .commonLine,
   .segmentLine, .segmentPinEnable, .biasMode, .regulatorCfg, .ladderTransition, .driverActive);
`default_nettype wire

// ===== bench/lcd_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model #(
   parameter int NUM_SEGS = 64,
   parameter int NUM_COMS = 8
) (
   // Panel electrodes and frame phase
   input wire logic [NUM_COMS-1:0] commonLine,
   input wire logic [NUM_SEGS-1:0] segmentLine,
   input wire logic framePhase,
   // What the glass shows
   output logic [NUM_SEGS-1:0] darkRow,
   output int selCom
);
   // --------------------------------
   // Decode
   // --------------------------------
   // Selected common swings against the phase; -1 while blank
   always_comb begin
      selCom = -1;
      for (int c = 0; c < NUM_COMS; c++) begin
         if (commonLine[c] != framePhase) begin
            selCom = c;
         end
      end
      darkRow = segmentLine ^ {NUM_SEGS{framePhase}};
   end
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import lcd_pkg::*;
();
   logic mclk, rstn, regWr, regRd, fastRcTick, secOscTick, lowPwrRcTick, cpuSleep;
   logic framePhase, ladderTransition, driverActive;
   logic [ADDR_W-1:0] regAddr;
   logic [7:0] regWdata, regRdata, rdv, commonLine;
   logic [63:0] segmentLine, segmentPinEnable, darkRow, expRow;
   lcd_bias_t biasMode;
   lcd_regulator_t regulatorCfg;
   int mdl [128];
   int err_total, check_count, seed, selCom, t0, code, cyc;
   lcd_segment_ctrl uut (.mclk, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
      .fastRcTick, .secOscTick, .lowPwrRcTick, .cpuSleep, .commonLine, .segmentLine,
      .framePhase, .segmentPinEnable, .biasMode, .regulatorCfg, .ladderTransition, .driverActive);
   lcd_panel_model panel (.commonLine, .segmentLine, .framePhase, .darkRow, .selCom);
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      fastRcTick <= 1'($random(seed));
   end
   // --------------------------------
   // Checking and bus tasks
   // --------------------------------
   task automatic fail(input string m);
      err_total++;
      $display("MISMATCH t=%0t %s", $time, m);
   endtask
   task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) fail($sformatf("byte %h exp %h", g, e));
   endtask
   task automatic cmp64(input logic [63:0] g, input logic [63:0] e);
      check_count++;
      if (g !== e) fail($sformatf("row %h exp %h", g, e));
   endtask
   task automatic cmpInt(input int g, input int e);
      check_count++;
      if (g != e) fail($sformatf("count %0d exp %0d", g, e));
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      #1 d = regRdata;
      @(posedge mclk);
   endtask
   task automatic chk(input logic [6:0] a, input logic [7:0] m);
      rd(a, rdv);
      cmp8(rdv & m, 8'(mdl[a]) & m);
   endtask
   task automatic initModel;
      foreach (mdl[i]) mdl[i] = 0;
      mdl[1] = RST_CHARGE_PUMP_CONTROL;
      mdl[2] = 8'h10;
   endtask
   task automatic chkAll;
      for (int a = 0; a < 128; a++) chk(7'(a), 8'hFF);
   endtask
   task automatic waitSel(input bit ph);
      int prev;
      prev = ph ? int'(framePhase) : selCom;
      repeat (12000) begin
         @(posedge mclk);
         #1;
         if ((ph ? int'(framePhase) : selCom) != prev) return;
      end
   endtask
   task automatic period(input int e, input bit ph);
      waitSel(ph);
      waitSel(ph);
      t0 = cyc;
      waitSel(ph);
      cmpInt(cyc - t0, e);
      @(posedge mclk);
   endtask
   task automatic report_and_stop;
      $display("Checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (80000) @(posedge mclk);
      fail("watchdog expired");
      report_and_stop();
   end
   // --------------------------------
   // Main sequence
   // --------------------------------
   initial begin
      {rstn, regWr, regRd, secOscTick, lowPwrRcTick, cpuSleep, fastRcTick} = '0;
      {regAddr, regWdata, err_total, check_count, cyc} = '0;
      seed = 6383;
      initModel();
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      chkAll();
      wr(7'h01, 8'hFF);
      mdl[1] = CPC_WRITABLE;
      wr(7'h02, 8'hBF);
      mdl[2] = 8'h9F;
      wr(7'h03, 8'hFF);
      wr(7'h00, 8'h3F);
      mdl[0] = 8'h1F;
      for (int a = 8; a < 128; a++) begin
         if (a < 16 || a >= 64) begin
            code = $random(seed);
            wr(7'(a), 8'(code));
            mdl[a] = code & 8'hFF;
         end
      end
      chkAll();
      for (int s = 0; s < 64; s++) expRow[s] = mdl[8 + s / 8][s % 8];
      cmp64(segmentPinEnable, expRow);
      for (int i = 0; i < 16; i++) begin
         code = i % 8;
         wr(7'h02, (i > 7 && (code == 1 || code == 2)) ? 8'h40 : 8'h00);
         wr(7'h00, 8'(code));
         @(posedge mclk);
         cmp8(8'(biasMode), code == 0 ? 8'h00 : (i > 7 && code < 3) ? 8'h01 : 8'h02);
      end
      mdl[2] = 8'h10;
      cpuSleep <= 1'b1;
      wr(7'h00, 8'hC8);
      chk(7'h02, 8'h20);
      wr(7'h00, 8'h88);
      mdl[2] = 8'h30;
      chk(7'h02, 8'h20);
      cpuSleep <= 1'b0;
      secOscTick <= 1'b1;
      wr(7'h00, 8'h89);
      for (int p = 0; p < 2; p++) begin
         wr(7'h02, 8'(p));
         period(1024 * (p + 1), 1'b0);
      end
      secOscTick <= 1'b0;
      lowPwrRcTick <= 1'b1;
      wr(7'h00, 8'h91);
      wr(7'h02, 8'h00);
      period(1024, 1'b0);
      wr(7'h00, 8'h94);
      repeat (40) begin
         repeat (150) @(posedge mclk);
         #1;
         if (selCom >= 0) begin
            for (int s = 0; s < 64; s++) expRow[s] = s < 60 && mdl[64 + 8 * selCom + s / 8][s % 8];
            cmp64(darkRow, expRow);
         end
      end
      @(posedge mclk);
      period(512, 1'b1);
      wr(OFS_PHASE_AND_PRESCALE, 8'h80);
      period(5120, 1'b1);
      // Refusal window opens when write_allow drops and lasts one prescaled count
      rdv = 8'h00;
      code = 0;
      for (int k = 0; k < 3000 && (code == 0 || rdv[4]); k++) begin
         code = rdv[4];
         rd(OFS_PHASE_AND_PRESCALE, rdv);
      end
      wr(OFS_PIXEL_DATA_0, ~8'(mdl[64]));
      mdl[0] = 8'hB4;
      chk(7'h00, 8'hFF);
      wr(7'h00, 8'hB4);
      chk(7'h00, 8'hFF);
      wr(7'h00, 8'h14);
      mdl[0] = 8'h14;
      chk(7'h00, 8'hFF);
      chk(7'h40, 8'hFF);
      rstn <= 1'b0;
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      initModel();
      chkAll();
      report_and_stop();
   end
endmodule
`default_nettype wire
